// ---- hw/cbgb_consts.svh ----
// Constants for the control bus glue bridge
// What this block does
// (R1) Control bus: 8-bit address, 8-bit data, read/write, enable, ack, irq.
// (R2) Control bus parity stays disabled; nothing generated or checked.
// (R3) Acknowledge and interrupt are open-drain, wired-OR among controllers.
// (R4) Master drops enable; address, direction, write data valid within 20 ns.
// (R5) Addressed controller pulls ack low when read data valid or write taken.
// (R6) Master raises enable after ack; controller then releases ack.
// (R7) Processor address phase held in a latch; low 8 bits drive bus.
// (R8) Data buffer enable low on any strobe; direction follows write strobe.
// (R9) PHY select low for strobe and address 8000..9FFF, from bits 15..13.
// (R10) MAC select low for strobe and address A000..BFFF.
// (R11) Selects registered, changing only on processor clock falling edge.
// (R12) Ready high when no strobe or ack low; else wait states.
// (R13) Each controller interrupt reaches the processor on its own line.
// (R14) Host side: two interrupts and two byte ports, read and write.
// (R15) Selects rise on first falling edge after both strobes go idle.
`ifndef CBGB_CONSTS_SVH
`define CBGB_CONSTS_SVH

`define CBGB_CLK_PERIOD_NS   10
`define CBGB_SETUP_NS        20
// Enable-to-valid time as whole clock cycles (longest time, rounded down)
`define CBGB_SETUP_CYC ((`CBGB_SETUP_NS / `CBGB_CLK_PERIOD_NS) > 0 ? \
                        (`CBGB_SETUP_NS / `CBGB_CLK_PERIOD_NS) : 1)
`define CBGB_DEC_MSB         15
`define CBGB_DEC_LSB         13
`define CBGB_PHY_WIN         3'h4
`define CBGB_MAC_WIN         3'h5
`define CBGB_BYTE_W          8
`define CBGB_ADDR_W          16

`endif

// ---- hw/cbgb_pkg.sv ----
// Types shared by the control bus glue bridge
package cbgb_pkg;

    // Control bus outputs of the bridge
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wdata_oe;
        logic       read;
    } cbgb_cbus_t;

    // Processor data returned through the buffer
    typedef struct packed {
        logic [7:0] rdata;
        logic       rdata_oe;
    } cbgb_cpu_t;

endpackage : cbgb_pkg

// ---- hw/cbgb_mailbox.sv ----
// One byte-wide host mailbox with a sticky pending flag
`timescale 1ns/100ps
module cbgb_mailbox (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       load_i,
    input  wire logic [7:0] data_i,
    input  wire logic       take_i,
    output logic      [7:0] data_o,
    output logic            pend_o
);
    import cbgb_pkg::*;

    logic [7:0] data_reg;
    logic       pend_reg;
    logic       pend_next;

    // A load in the same cycle as a take keeps the flag set
    assign pend_next = load_i | (pend_reg & ~take_i);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_reg <= 8'h00;
            pend_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (load_i) begin
                data_reg <= data_i;
            end
            pend_reg <= pend_next;
        end
    end

    assign data_o = data_reg;
    assign pend_o = pend_reg;

endmodule : cbgb_mailbox

// ---- hw/cbgb_bridge.sv ----
// Processor to control bus bridge: latch, buffer, decode, wait states
`timescale 1ns/100ps
`include "cbgb_consts.svh"
module cbgb_bridge (
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    input  wire logic              clk_en_i,
    // Processor side
    input  wire logic              cpu_clock_i,
    input  wire logic              cpu_ale_i,
    input  wire logic [15:0]       cpu_ad_i,
    input  wire logic              cpu_rd_n_i,
    input  wire logic              cpu_wr_n_i,
    output cbgb_pkg::cbgb_cpu_t    cpu_data_o,
    output logic                   cpu_ready_o,
    output logic                   cpu_clock_inverted_o,
    output logic                   cpu_phy_irq_n_o,
    output logic                   cpu_mac_irq_n_o,
    // Control bus side
    output cbgb_pkg::cbgb_cbus_t   cbus_o,
    input  wire logic [7:0]        cb_data_i,
    input  wire logic              ack_n_i,
    input  wire logic              phy_irq_n_i,
    input  wire logic              mac_irq_n_i,
    output logic                   phy_select_n_o,
    output logic                   mac_select_n_o,
    output logic                   data_buffer_enable_n_o,
    output logic                   buffer_dir_o,
    // Host side
    input  wire logic              host_wr_stb_i,
    input  wire logic [7:0]        host_wr_data_i,
    input  wire logic              cpu_host_take_i,
    output logic      [7:0]        cpu_host_data_o,
    output logic                   cpu_host_irq_o,
    input  wire logic              cpu_tx_stb_i,
    input  wire logic              host_rd_take_i,
    output logic      [7:0]        host_rd_data_o,
    output logic                   host_irq_o
);
    import cbgb_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    // Asynchronous assert, release after two clock edges. Only the second
    // flop feeds the design, so a release landing near an edge cannot
    // reach some flops a cycle before the others.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    logic [15:0] addr_reg;
    logic        cpu_clk_reg;
    logic        cpu_fall;
    logic        any_strobe;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [2:0]  win;
    logic        phy_hit;
    logic        mac_hit;
    logic [15:0] addr_now;
    logic        ready_next;
    logic        read_next;
    logic        rdata_oe_next;
    logic        buf_en_n_next;

    // Latch is transparent while ALE is high, so decode sees it at once
    assign addr_now   = cpu_ale_i ? cpu_ad_i : addr_reg;          // see (R7)
    assign wr_strobe  = ~cpu_wr_n_i;
    assign rd_strobe  = ~cpu_rd_n_i;
    assign any_strobe = wr_strobe | rd_strobe;                    // see (R8)
    assign win        = addr_now[`CBGB_DEC_MSB:`CBGB_DEC_LSB];    // see (R9)
    assign phy_hit    = any_strobe & (win == `CBGB_PHY_WIN);      // see (R9)
    assign mac_hit    = any_strobe & (win == `CBGB_MAC_WIN);      // see (R10)
    // Processor clock is a plain synchronous input; catch its fall.
    // A fall is only seen while the clock enable is high, so a frozen
    // cycle can delay a select by one processor clock.
    assign cpu_fall   = cpu_clk_reg & ~cpu_clock_i;               // see (R11)
    // Ack is open-drain and wired-OR, so low from any controller counts
    assign ready_next = ~any_strobe | ~ack_n_i;            // see (R12) (R3)
    // Both strobes low is taken as a write, so the buffer never fights
    // the processor for the data lines when the strobes overlap
    assign read_next     = ~wr_strobe;                            // see (R1)
    assign rdata_oe_next = rd_strobe & ~wr_strobe;                // see (R8)
    assign buf_en_n_next = ~any_strobe;                           // see (R8)

    // ------------------------------------------------------------
    // Address latch and clock edge tracking
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg    <= 16'h0000;
            cpu_clk_reg <= 1'b0;
        end else if (clk_en_i) begin
            addr_reg    <= addr_now;                              // see (R7)
            cpu_clk_reg <= cpu_clock_i;
        end
    end

    // ------------------------------------------------------------
    // Chip selects
    // ------------------------------------------------------------
    // Delaying to the falling edge gives write data its 20 ns lead; the
    // cost is up to one processor clock of extra latency per access.
    // Selects rise only on a fall after the strobes end, and the strobes
    // end only once ack has let ready through, so the controller sees
    // its enable rise after acking and can then release ack. see (R6)
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            phy_select_n_o <= 1'b1;
            mac_select_n_o <= 1'b1;
        end else if (clk_en_i && cpu_fall) begin
            phy_select_n_o <= ~phy_hit;                   // see (R11) (R15)
            mac_select_n_o <= ~mac_hit;                   // see (R11) (R15)
        end
    end

    // ------------------------------------------------------------
    // Control bus drive and data buffer
    // ------------------------------------------------------------
    // Address and direction settle ahead of the select edge (R4 is the
    // master's duty, met because selects trail these by a clock half).
    // No parity line is driven or checked.                   see (R2)
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            cbus_o                 <= '{addr: 8'h00, wdata: 8'h00,
                                        wdata_oe: 1'b0, read: 1'b1};
            cpu_data_o             <= '{rdata: 8'h00, rdata_oe: 1'b0};
            data_buffer_enable_n_o <= 1'b1;
            buffer_dir_o           <= 1'b0;
        end else if (clk_en_i) begin
            cbus_o.addr            <= addr_now[7:0];       // see (R7) (R4)
            cbus_o.read            <= read_next;                  // see (R1)
            cbus_o.wdata           <= cpu_ad_i[7:0];
            cbus_o.wdata_oe        <= wr_strobe;                  // see (R8)
            // Sampled each cycle; it is valid once ack is low, the same
            // edge at which ready rises, so the processor takes it then
            cpu_data_o.rdata       <= cb_data_i;                  // see (R5)
            cpu_data_o.rdata_oe    <= rdata_oe_next;              // see (R8)
            data_buffer_enable_n_o <= buf_en_n_next;              // see (R8)
            buffer_dir_o           <= wr_strobe;                  // see (R8)
        end
    end

    // ------------------------------------------------------------
    // Ready, interrupts and inverted clock
    // ------------------------------------------------------------
    // Ready is registered, so the processor sees ack one clock late; this
    // costs a wait state but keeps the output free of glitches.
    // Controller interrupts stay separate so no bus polling is needed
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_ready_o          <= 1'b1;
            cpu_phy_irq_n_o      <= 1'b1;
            cpu_mac_irq_n_o      <= 1'b1;
            cpu_clock_inverted_o <= 1'b1;
        end else if (clk_en_i) begin
            cpu_ready_o          <= ready_next;                   // see (R12)
            cpu_phy_irq_n_o      <= phy_irq_n_i;           // see (R13) (R3)
            cpu_mac_irq_n_o      <= mac_irq_n_i;           // see (R13) (R3)
            cpu_clock_inverted_o <= ~cpu_clock_i;
        end
    end

    // ------------------------------------------------------------
    // Host byte ports
    // ------------------------------------------------------------
    logic [7:0] rx_data;
    logic       rx_pend;
    logic [7:0] tx_data;
    logic       tx_pend;

    // The mailboxes have no address window; their strobes are wired in
    // directly, and a load meeting a take keeps the pending flag set.
    // Host write port: host loads, processor takes
    cbgb_mailbox u_host_wr (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n),
        .clk_en_i (clk_en_i),
        .load_i   (host_wr_stb_i),
        .data_i   (host_wr_data_i),
        .take_i   (cpu_host_take_i),
        .data_o   (rx_data),
        .pend_o   (rx_pend)
    );                                                            // see (R14)

    // Host read port: processor loads its low data byte, host takes
    cbgb_mailbox u_host_rd (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n),
        .clk_en_i (clk_en_i),
        .load_i   (cpu_tx_stb_i),
        .data_i   (cpu_ad_i[7:0]),
        .take_i   (host_rd_take_i),
        .data_o   (tx_data),
        .pend_o   (tx_pend)
    );                                                            // see (R14)

    // Register the mailbox view so every output leaves a flip-flop
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_host_data_o <= 8'h00;
            cpu_host_irq_o  <= 1'b0;
            host_rd_data_o  <= 8'h00;
            host_irq_o      <= 1'b0;
        end else if (clk_en_i) begin
            cpu_host_data_o <= rx_data;
            cpu_host_irq_o  <= rx_pend;                           // see (R14)
            host_rd_data_o  <= tx_data;
            host_irq_o      <= tx_pend;                           // see (R14)
        end
    end

endmodule : cbgb_bridge

// ---- test/cbgb_ctl_dev.sv ----
// Behavioural controller device on the register control bus
`timescale 1ns/100ps
module cbgb_ctl_dev #(
    parameter int LAT = 1
) (
    input  wire logic                 clock_i,
    input  wire logic                 select_n_i,
    input  wire cbgb_pkg::cbgb_cbus_t cbus_i,
    output logic                      ack_n_o,
    output logic                      oe_o,
    output logic                [7:0] data_o
);
    import cbgb_pkg::*;
    // 8-bit register space, no parity line at all
    logic [7:0] mem [256];
    int         cnt = 0;
    initial begin
        ack_n_o = 1'b1;
        oe_o = 1'b0;
        data_o = 8'h00;
    end
    // LAT sets prompt or slow answers; idle data toggles so stale bytes show
    always @(posedge clock_i) begin
        if (select_n_i) begin
            cnt <= 0;
            ack_n_o <= 1'b1; // Release to pull-up
            oe_o <= 1'b0;
            data_o <= ~data_o;
        end else if (cnt < LAT) begin
            cnt <= cnt + 1;
        end else if (ack_n_o) begin
            if (cbus_i.read) begin
                oe_o <= 1'b1;
                data_o <= mem[cbus_i.addr];
            end else begin
                mem[cbus_i.addr] <= cbus_i.wdata;
            end
            ack_n_o <= 1'b0; // Data ready or taken
        end
    end
endmodule : cbgb_ctl_dev

// ---- test/cbgb_bridge_assertions.sv ----
// Concurrent checks on the bridge ports
`timescale 1ns/100ps
`include "cbgb_consts.svh"
module cbgb_bridge_assertions (
    input  wire logic                 clock_i,
    input  wire logic                 nrst_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 cpu_clock_i,
    input  wire logic                 cpu_ale_i,
    input  wire logic [15:0]          cpu_ad_i,
    input  wire logic                 cpu_rd_n_i,
    input  wire logic                 cpu_wr_n_i,
    input  wire logic                 ack_n_i,
    input  wire logic                 cpu_ready_o,
    input  wire logic                 phy_select_n_o,
    input  wire logic                 mac_select_n_o,
    input  wire logic                 data_buffer_enable_n_o,
    input  wire logic                 buffer_dir_o,
    input  wire cbgb_pkg::cbgb_cbus_t cbus_o
);
    import cbgb_pkg::*;
    // Skip the reset synchroniser, the first clock samples, and any cycle
    // that follows one frozen by the clock enable
    logic [2:0]  up_cnt;
    logic        en_q;
    logic [15:0] hold;
    wire         live = up_cnt[2] && clk_en_i && en_q;
    wire         strb = !cpu_rd_n_i || !cpu_wr_n_i;
    wire  [15:0] lat = cpu_ale_i ? cpu_ad_i : hold;
    wire         phy_hit = strb && lat[15:13] == `CBGB_PHY_WIN;
    wire         mac_hit = strb && lat[15:13] == `CBGB_MAC_WIN;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_cnt <= 3'h0;
            en_q   <= 1'b0;
        end else begin
            if (!up_cnt[2]) up_cnt <= up_cnt + 3'h1;
            en_q <= clk_en_i;
        end
    end
    always_ff @(posedge clock_i) begin
        if (cpu_ale_i) hold <= cpu_ad_i;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence clk_fall;
        live ##0 ($past(cpu_clock_i) && !cpu_clock_i);
    endsequence
    sequence bus_idle;
        cpu_rd_n_i && cpu_wr_n_i;
    endsequence
    buf_en_a: assert property (live |=>
        data_buffer_enable_n_o == !$past(strb)) else $error("buffer enable");
    buf_dir_a: assert property (live |=>
        buffer_dir_o == !$past(cpu_wr_n_i)) else $error("buffer direction");
    ready_a: assert property (live |=>
        cpu_ready_o == $past(!strb || !ack_n_i)) else $error("ready level");
    phy_sel_a: assert property (clk_fall |=>
        phy_select_n_o == !$past(phy_hit)) else $error("phy select");
    mac_sel_a: assert property (clk_fall |=>
        mac_select_n_o == !$past(mac_hit)) else $error("mac select");
    sel_hold_a: assert property (live && !(cpu_clock_i == 1'b0 &&
        $past(cpu_clock_i)) |=> $stable({phy_select_n_o, mac_select_n_o}))
        else $error("select changed off a fall");
    sel_drop_a: assert property (clk_fall ##0 bus_idle |=>
        phy_select_n_o && mac_select_n_o) else $error("select stuck");
    wr_data_a: assert property (live && !cpu_wr_n_i |=>
        !cbus_o.read && cbus_o.wdata_oe &&
        cbus_o.wdata == $past(cpu_ad_i[7:0]))
        else $error("write data");
    bus_addr_a: assert property (live && strb |=>
        cbus_o.addr == $past(lat[7:0])) else $error("bus address");
endmodule : cbgb_bridge_assertions

bind cbgb_bridge cbgb_bridge_assertions cbgb_bridge_assertions_inst (
    .clock_i, .nrst_i, .clk_en_i, .cpu_clock_i, .cpu_ale_i, .cpu_ad_i,
    .cpu_rd_n_i,
    .cpu_wr_n_i, .ack_n_i, .cpu_ready_o, .phy_select_n_o, .mac_select_n_o,
    .data_buffer_enable_n_o, .buffer_dir_o, .cbus_o);

// ---- test/cbgb_bridge_tb.sv ----
// Self-checking bench for the control bus glue bridge
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch at %0t got %0h exp %0h", $time, (a), (e)); end end
module cbgb_bridge_tb;
    import cbgb_pkg::*;
    logic clock_i = 0, nrst_i = 0, cpu_clock_i = 0, cpu_ale_i = 0;
    logic clk_en_i = 1, cpu_clock_inverted_o;
    logic cpu_rd_n_i = 1, cpu_wr_n_i = 1, phy_irq_n_i = 1, mac_irq_n_i = 1;
    logic host_wr_stb_i = 0, cpu_host_take_i = 0, cpu_tx_stb_i = 0;
    logic host_rd_take_i = 0, cpu_ready_o, cpu_phy_irq_n_o, cpu_mac_irq_n_o;
    logic phy_select_n_o, mac_select_n_o, data_buffer_enable_n_o;
    logic buffer_dir_o, cpu_host_irq_o, host_irq_o, p_ack, m_ack, p_oe, m_oe;
    logic [15:0] cpu_ad_i = 16'h0000;
    logic [7:0]  host_wr_data_i = 8'h00, cpu_host_data_o, host_rd_data_o;
    logic [7:0]  p_d, m_d;
    cbgb_cpu_t   cpu_data_o;
    cbgb_cbus_t  cbus_o;
    int          n_fail = 0, checks = 0;
    wire         ack_n_i = p_ack & m_ack; // Wired acknowledge
    // Undriven data bus changes only while one device is selected, so stale reads are caught
    wire [7:0]   cb_data_i = p_oe ? p_d : m_oe ? m_d : ~(p_d ^ m_d);
    cbgb_bridge cbgb_bridge_inst (.clock_i, .nrst_i, .clk_en_i,
        .cpu_clock_i, .cpu_ale_i, .cpu_ad_i, .cpu_rd_n_i, .cpu_wr_n_i,
        .cpu_data_o, .cpu_ready_o, .cpu_clock_inverted_o, .cpu_phy_irq_n_o,
        .cpu_mac_irq_n_o, .cbus_o, .cb_data_i, .ack_n_i, .phy_irq_n_i,
        .mac_irq_n_i, .phy_select_n_o, .mac_select_n_o, .data_buffer_enable_n_o,
        .buffer_dir_o, .host_wr_stb_i, .host_wr_data_i, .cpu_host_take_i,
        .cpu_host_data_o, .cpu_host_irq_o, .cpu_tx_stb_i, .host_rd_take_i,
        .host_rd_data_o, .host_irq_o);
    // Fast PHY side, slow MAC side so both wait lengths are exercised
    cbgb_ctl_dev #(.LAT(1)) phy_dev_inst (.clock_i, .select_n_i(phy_select_n_o),
        .cbus_i(cbus_o), .ack_n_o(p_ack), .oe_o(p_oe), .data_o(p_d));
    cbgb_ctl_dev #(.LAT(6)) mac_dev_inst (.clock_i, .select_n_i(mac_select_n_o),
        .cbus_i(cbus_o), .ack_n_o(m_ack), .oe_o(m_oe), .data_o(m_d));
    initial forever #5 clock_i = ~clock_i;
    initial forever begin
        repeat (2) @(posedge clock_i);
        #1 cpu_clock_i = ~cpu_clock_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    // One processor cycle; sel is {phy, mac} expected to assert
    task automatic access(input logic [15:0] a, input logic w,
                          input logic [7:0] d, input logic [1:0] sel);
        logic [1:0] seen;
        seen = 2'b00;
        cpu_ale_i = 1'b1; // Address settles before the strobe
        cpu_ad_i = a;
        tick(1);
        cpu_ale_i = 1'b0;
        cpu_ad_i = {8'h00, d};
        cpu_wr_n_i = !w;
        cpu_rd_n_i = w;
        for (int i = 0; i < 20; i++) begin
            tick(1);
            seen |= {!phy_select_n_o, !mac_select_n_o};
            if (i > 0 && cpu_ready_o) break;
        end
        `CHK(seen, sel)
        `CHK(cpu_ready_o, |sel)
        `CHK({data_buffer_enable_n_o, buffer_dir_o}, {1'b0, w})
        `CHK(cbus_o.addr, a[7:0])
        `CHK({cbus_o.read, cbus_o.wdata_oe}, {!w, w})
        `CHK(cpu_data_o.rdata_oe, !w)
        if (w) `CHK(cbus_o.wdata, d)
        if (!w) `CHK(cpu_data_o.rdata, d)
        cpu_wr_n_i = 1'b1;
        cpu_rd_n_i = 1'b1;
        tick(6);
        `CHK({phy_select_n_o, mac_select_n_o, cpu_ready_o}, 3'h7)
        `CHK(ack_n_i, 1'b1)
    endtask : access
    task automatic t_windows;
        logic [15:0] a [6] = '{16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000,
                               16'hBFFF, 16'hC000};
        logic [1:0]  s [6] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
        foreach (a[i]) access(a[i], 1'b1, a[i][7:0] ^ 8'h3C, s[i]);
        for (int i = 1; i < 5; i++) access(a[i], 1'b0, a[i][7:0] ^ 8'h3C, s[i]);
        $display("test windows done");
    endtask : t_windows
    task automatic t_irq;
        logic c;
        phy_irq_n_i = 1'b0;
        tick(1);
        `CHK({cpu_phy_irq_n_o, cpu_mac_irq_n_o}, 2'h1)
        phy_irq_n_i = 1'b1;
        mac_irq_n_i = 1'b0;
        tick(1);
        `CHK({cpu_phy_irq_n_o, cpu_mac_irq_n_o}, 2'h2)
        mac_irq_n_i = 1'b1;
        // Inverted processor clock trails the sampled clock by one edge
        repeat (4) begin
            @(posedge clock_i);
            c = cpu_clock_i;
            #1;
            `CHK(cpu_clock_inverted_o, !c)
        end
        $display("test irq done");
    endtask : t_irq
    task automatic t_host;
        host_wr_data_i = 8'hAB;
        host_wr_stb_i = 1'b1;
        cpu_ad_i = 16'h00C3;
        cpu_tx_stb_i = 1'b1;
        tick(1);
        host_wr_stb_i = 1'b0;
        cpu_tx_stb_i = 1'b0;
        tick(2);
        `CHK({cpu_host_irq_o, cpu_host_data_o}, 9'h1AB)
        `CHK({host_irq_o, host_rd_data_o}, 9'h1C3)
        cpu_host_take_i = 1'b1;
        host_rd_take_i = 1'b1;
        tick(1);
        cpu_host_take_i = 1'b0;
        host_rd_take_i = 1'b0;
        tick(2);
        `CHK({cpu_host_irq_o, host_irq_o}, 2'h0)
        host_wr_data_i = 8'h5A;
        host_wr_stb_i = 1'b1;
        tick(1);
        host_wr_data_i = 8'h66;
        cpu_host_take_i = 1'b1; // Take meets a fresh load: the set wins
        tick(1);
        host_wr_stb_i = 1'b0;
        cpu_host_take_i = 1'b0;
        tick(2);
        `CHK({cpu_host_irq_o, cpu_host_data_o}, 9'h166)
        cpu_host_take_i = 1'b1;
        tick(1);
        cpu_host_take_i = 1'b0;
        tick(2);
        `CHK(cpu_host_irq_o, 1'b0)
        $display("test host done");
    endtask : t_host
    task automatic t_freeze;
        clk_en_i = 1'b0; // Frozen: strobes and loads must leave no trace
        host_wr_data_i = 8'h99;
        host_wr_stb_i = 1'b1;
        cpu_wr_n_i = 1'b0;
        tick(1);
        host_wr_stb_i = 1'b0;
        cpu_wr_n_i = 1'b1;
        tick(2);
        `CHK({cpu_host_irq_o, cpu_host_data_o}, 9'h066)
        `CHK(data_buffer_enable_n_o, 1'b1)
        clk_en_i = 1'b1;
        tick(3);
        `CHK({cpu_host_irq_o, cpu_host_data_o}, 9'h066)
        $display("test freeze done");
    endtask : t_freeze
    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        tick(10);
        nrst_i = 1'b1;
        tick(4);
        t_windows();
        t_irq();
        t_host();
        t_freeze();
        results();
    end
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule : cbgb_bridge_tb
